// >>> rtl/rbm_regs.sv
// rbm_regs: radio mode and configuration register bank with serial port
//
// Function
// - bit 7 enters or leaves receive mode
// - bit 6 enters or leaves transmit mode
// - bit 5 picks code half, normal 32-chip only
// - bit 4 bypasses lock wait before count
// - bit 3 selects register amplifier control
// - bit 2 drives amplifier under register control
// - rate bit 2 selects 32 or 64 chips
// - rate bit 1 enables double rate, 32-chip
// - double rate splits code into halves
// - normal 32-chip rate allows two codes
// - rate bit 0 picks 12x or 6x, normal 32-chip only
// - two-bit field sets interrupt pin style
// - serializer bit 3 picks byte or bit mode
// - end-of-frame after programmed gap of bit times
// - end-of-frame moves bits, may interrupt
// - zero gap fires at first invalid bit
// - enabled end-of-frame asserts irq, read clears
// - command byte: write, increment, six-bit address
`timescale 1ns/1ps
module rbm_regs (
  // clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  // serial register port, mode 0, sampled synchronously
  input  wire logic       spi_sck_i,
  input  wire logic       spi_ss_n_i,
  input  wire logic       spi_mosi_i,
  output logic            spi_miso_o,
  // correlator bit streams
  input  wire logic       bit_tick_i,
  input  wire logic       bit_valid_a_i,
  input  wire logic       bit_data_a_i,
  input  wire logic       bit_valid_b_i,
  input  wire logic       bit_data_b_i,
  input  wire logic       synth_lock_i,
  // mode outputs
  output logic            rx_mode_o,
  output logic            tx_mode_o,
  output logic            code_upper_half_o,
  output logic            code_width32_o,
  output logic            double_rate_o,
  output logic            sample12_o,
  output logic            dual_code_o,
  output logic            amp_on_o,
  output logic            byte_mode_enable_o,
  output logic            bit_mode_enable_o,
  output logic            synth_ready_o,
  // interrupt pin
  output logic            irq_o,
  output logic            irq_oe_o
);
  // -------------------------------------------------------------------------
  // registers
  // -------------------------------------------------------------------------
  logic [7:0] mode_ctrl_r;
  logic [7:0] code_rate_r;
  logic [7:0] irq_cfg_r;
  logic [7:0] ser_ctrl_r;
  logic [7:0] rx_irq_en_r;
  logic [7:0] settle_cnt_r;
  logic [7:0] rx_stat_r;
  logic [7:0] rx_data_a_r;
  logic [7:0] rx_data_b_r;

  // -------------------------------------------------------------------------
  // serial shifter
  // -------------------------------------------------------------------------
  logic       sck_d_r;
  logic [2:0] bit_cnt_r;
  logic [7:0] sh_in_r;
  logic [7:0] sh_out_r;
  logic       have_cmd_r;
  logic       wr_r;
  logic       inc_r;
  logic [5:0] addr_r;
  logic       rise;
  logic       fall;
  logic       byte_done;
  logic [7:0] byte_in;
  logic       wr_stb;
  logic       rd_stb;
  logic [5:0] rd_addr;

  assign rise      = !spi_ss_n_i && spi_sck_i && !sck_d_r;
  assign fall      = !spi_ss_n_i && !spi_sck_i && sck_d_r;
  assign byte_done = rise && bit_cnt_r == 3'h7;
  assign byte_in   = {sh_in_r[6:0], spi_mosi_i};
  assign wr_stb    = byte_done && have_cmd_r && wr_r;
  assign rd_addr   = (byte_done && !have_cmd_r) ? byte_in[5:0] :
                     (inc_r ? addr_r + 6'h01 : addr_r);
  assign rd_stb    = byte_done && !(have_cmd_r ? wr_r : byte_in[7]);

  function automatic logic [7:0] read_mux(input logic [5:0] a);
    case (a)
      rbm_pkg::ADDR_MODE_CTRL:  read_mux = mode_ctrl_r;
      rbm_pkg::ADDR_CODE_RATE:  read_mux = code_rate_r;
      rbm_pkg::ADDR_IRQ_CFG:    read_mux = irq_cfg_r;
      rbm_pkg::ADDR_SER_CTRL:   read_mux = ser_ctrl_r;
      rbm_pkg::ADDR_RX_IRQ_EN:  read_mux = rx_irq_en_r;
      rbm_pkg::ADDR_RX_STATUS:  read_mux = rx_stat_r;
      rbm_pkg::ADDR_RX_DATA_A:  read_mux = rx_data_a_r;
      rbm_pkg::ADDR_RX_DATA_B:  read_mux = rx_data_b_r;
      rbm_pkg::ADDR_SETTLE_CNT: read_mux = settle_cnt_r;
      default:                  read_mux = 8'h00;
    endcase
  endfunction

  always_ff @(posedge ref_clk_i) begin
    if (rst_i || spi_ss_n_i) begin
      sck_d_r    <= 1'b0;
      bit_cnt_r  <= 3'h0;
      sh_in_r    <= 8'h00;
      have_cmd_r <= 1'b0;
      wr_r       <= 1'b0;
      inc_r      <= 1'b0;
      addr_r     <= 6'h00;
    end else begin
      sck_d_r <= spi_sck_i;
      if (rise) begin
        bit_cnt_r <= bit_cnt_r + 3'h1;
        sh_in_r   <= byte_in;
      end
      if (byte_done && !have_cmd_r) begin
        have_cmd_r <= 1'b1;
        wr_r       <= byte_in[rbm_pkg::CMD_WRITE];
        inc_r      <= byte_in[rbm_pkg::CMD_INCR];
        addr_r     <= byte_in[5:0];
      end else if (byte_done && inc_r) begin
        addr_r <= addr_r + 6'h01;
      end
    end
  end

  // read data loads at the end of each byte of a read transfer, shifts on falling edge
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || spi_ss_n_i) begin
      sh_out_r   <= 8'h00;
      spi_miso_o <= 1'b0;
    end else if (rd_stb) begin
      sh_out_r   <= read_mux(rd_addr);
      spi_miso_o <= spi_miso_o;
    end else if (fall) begin
      spi_miso_o <= sh_out_r[7];
      sh_out_r   <= {sh_out_r[6:0], 1'b0};
    end
  end

  // -------------------------------------------------------------------------
  // writable registers; reserved bits are forced to zero
  // -------------------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      mode_ctrl_r  <= rbm_pkg::RST_MODE_CTRL;
      code_rate_r  <= rbm_pkg::RST_CODE_RATE;
      irq_cfg_r    <= rbm_pkg::RST_IRQ_CFG;
      ser_ctrl_r   <= rbm_pkg::RST_SER_CTRL;
      rx_irq_en_r  <= rbm_pkg::RST_RX_IRQ_EN;
      settle_cnt_r <= rbm_pkg::RST_SETTLE_CNT;
    end else if (wr_stb) begin
      case (addr_r)
        rbm_pkg::ADDR_MODE_CTRL:
          mode_ctrl_r <= byte_in & rbm_pkg::MASK_MODE_CTRL;
        rbm_pkg::ADDR_CODE_RATE:
          code_rate_r <= byte_in & rbm_pkg::MASK_CODE_RATE;
        rbm_pkg::ADDR_IRQ_CFG:
          irq_cfg_r <= byte_in & rbm_pkg::MASK_IRQ_CFG;
        rbm_pkg::ADDR_SER_CTRL:
          ser_ctrl_r <= byte_in & rbm_pkg::MASK_SER_CTRL;
        rbm_pkg::ADDR_RX_IRQ_EN:  rx_irq_en_r  <= byte_in;
        rbm_pkg::ADDR_SETTLE_CNT: settle_cnt_r <= byte_in;
        default: ;
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // mode decode
  // -------------------------------------------------------------------------
  logic w32;
  logic dbl;
  assign w32 = code_rate_r[rbm_pkg::CR_WIDTH32];
  assign dbl = w32 && code_rate_r[rbm_pkg::CR_DOUBLE];

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rx_mode_o          <= 1'b0;
      tx_mode_o          <= 1'b0;
      code_upper_half_o  <= 1'b0;
      code_width32_o     <= 1'b0;
      double_rate_o      <= 1'b0;
      sample12_o         <= 1'b0;
      dual_code_o        <= 1'b0;
      amp_on_o           <= 1'b0;
      byte_mode_enable_o <= 1'b0;
      bit_mode_enable_o  <= 1'b0;
    end else begin
      rx_mode_o <= mode_ctrl_r[rbm_pkg::MC_RX_EN];
      tx_mode_o <= mode_ctrl_r[rbm_pkg::MC_TX_EN];
      code_upper_half_o <= w32 && !dbl && mode_ctrl_r[rbm_pkg::MC_HALF_SEL];
      code_width32_o <= w32;
      double_rate_o <= dbl;
      sample12_o <= w32 && !dbl && code_rate_r[rbm_pkg::CR_SAMPLE12];
      dual_code_o <= w32 && !dbl;
      amp_on_o <= mode_ctrl_r[rbm_pkg::MC_AMP_MAN] ?
                  mode_ctrl_r[rbm_pkg::MC_AMP_ON] :
                  (mode_ctrl_r[rbm_pkg::MC_TX_EN] && synth_ready_o);
      byte_mode_enable_o <= ser_ctrl_r[rbm_pkg::SC_BYTE_MODE];
      bit_mode_enable_o  <= !ser_ctrl_r[rbm_pkg::SC_BYTE_MODE];
    end
  end

  // -------------------------------------------------------------------------
  // settle sequencer and frame detectors
  // -------------------------------------------------------------------------
  rbm_settle u_settle (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .start_i   (mode_ctrl_r[rbm_pkg::MC_RX_EN] ||
                mode_ctrl_r[rbm_pkg::MC_TX_EN]),
    .bypass_i  (mode_ctrl_r[rbm_pkg::MC_LOCK_BYP]),
    .count_i   (settle_cnt_r),
    .lock_i    (synth_lock_i),
    .ready_o   (synth_ready_o)
  );

  logic       rx_on;
  logic       eof_a;
  logic       eof_b;
  logic       full_a;
  logic       full_b;
  logic [7:0] data_a;
  logic [7:0] data_b;
  assign rx_on = mode_ctrl_r[rbm_pkg::MC_RX_EN];

  rbm_eof u_eof_a (
    .ref_clk_i   (ref_clk_i),
    .rst_i       (rst_i),
    .rx_on_i     (rx_on),
    .gap_len_i   (ser_ctrl_r[2:0]),
    .bit_tick_i  (bit_tick_i),
    .bit_valid_i (bit_valid_a_i),
    .bit_data_i  (bit_data_a_i),
    .eof_o       (eof_a),
    .full_o      (full_a),
    .data_o      (data_a)
  );

  // channel b only runs in normal 32-chip mode
  rbm_eof u_eof_b (
    .ref_clk_i   (ref_clk_i),
    .rst_i       (rst_i),
    .rx_on_i     (rx_on && w32 && !dbl),
    .gap_len_i   (ser_ctrl_r[2:0]),
    .bit_tick_i  (bit_tick_i),
    .bit_valid_i (bit_valid_b_i),
    .bit_data_i  (bit_data_b_i),
    .eof_o       (eof_b),
    .full_o      (full_b),
    .data_o      (data_b)
  );

  // -------------------------------------------------------------------------
  // receive status: set wins over the read clear
  // -------------------------------------------------------------------------
  logic       stat_rd;
  logic [7:0] stat_set;
  assign stat_rd  = rd_stb && rd_addr == rbm_pkg::ADDR_RX_STATUS;
  assign stat_set = {2'b00, eof_b, full_b, 2'b00, eof_a, full_a};

  always_ff @(posedge ref_clk_i) begin
    if (rst_i || !rx_on) begin
      rx_stat_r <= 8'h00;
    end else if (stat_rd) begin
      rx_stat_r <= stat_set;
    end else begin
      rx_stat_r <= rx_stat_r | stat_set;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rx_data_a_r <= 8'h00;
      rx_data_b_r <= 8'h00;
    end else begin
      if (full_a) begin
        rx_data_a_r <= data_a;
      end
      if (full_b) begin
        rx_data_b_r <= data_b;
      end
    end
  end

  // -------------------------------------------------------------------------
  // interrupt pin
  // -------------------------------------------------------------------------
  logic irq_act;
  assign irq_act = rx_on && |(rx_stat_r & rx_irq_en_r);

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      irq_o    <= 1'b0;
      irq_oe_o <= 1'b1;
    end else begin
      case (irq_cfg_r[1:0])
        rbm_pkg::IRQ_OPEN_SRC: begin
          irq_o    <= 1'b1;
          irq_oe_o <= irq_act;
        end
        rbm_pkg::IRQ_OPEN_DRN: begin
          irq_o    <= 1'b0;
          irq_oe_o <= irq_act;
        end
        rbm_pkg::IRQ_PP_HIGH: begin
          irq_o    <= irq_act;
          irq_oe_o <= 1'b1;
        end
        default: begin
          irq_o    <= !irq_act;
          irq_oe_o <= 1'b1;
        end
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------------
  property p_rx_follow;
    @(posedge ref_clk_i) disable iff (rst_i)
      ##1 rx_mode_o == $past(mode_ctrl_r[rbm_pkg::MC_RX_EN]);
  endproperty
  a_rx_follow: assert property (p_rx_follow)
    else $error("receive mode does not follow control");

  property p_amp_manual;
    @(posedge ref_clk_i) disable iff (rst_i)
      mode_ctrl_r[rbm_pkg::MC_AMP_MAN] |=>
        amp_on_o == $past(mode_ctrl_r[rbm_pkg::MC_AMP_ON]);
  endproperty
  a_amp_manual: assert property (p_amp_manual)
    else $error("amplifier ignores manual enable");

  property p_sample_gate;
    @(posedge ref_clk_i) disable iff (rst_i)
      (!code_width32_o || double_rate_o) |-> !sample12_o;
  endproperty
  a_sample_gate: assert property (p_sample_gate)
    else $error("12x sampling outside normal 32-chip mode");

  property p_irq_pp;
    @(posedge ref_clk_i) disable iff (rst_i)
      (irq_cfg_r[1:0] == rbm_pkg::IRQ_PP_HIGH && irq_act) [*2] |-> irq_o;
  endproperty
  a_irq_pp: assert property (p_irq_pp)
    else $error("push-pull high irq not asserted");

  property p_eof_sticky;
    @(posedge ref_clk_i) disable iff (rst_i)
      (eof_a && rx_on) |=> rx_stat_r[rbm_pkg::IE_EOF_A];
  endproperty
  a_eof_sticky: assert property (p_eof_sticky)
    else $error("end-of-frame status lost");
endmodule

// >>> inc/rbm_pkg.sv
// rbm_pkg: shared constants for the radio mode configuration register bank
package rbm_pkg;
  // -------------------------------------------------------------------------
  // register addresses (six-bit address space)
  // -------------------------------------------------------------------------
  localparam logic [5:0] ADDR_MODE_CTRL  = 6'h03;
  localparam logic [5:0] ADDR_CODE_RATE  = 6'h04;
  localparam logic [5:0] ADDR_IRQ_CFG    = 6'h05;
  localparam logic [5:0] ADDR_SER_CTRL   = 6'h06;
  localparam logic [5:0] ADDR_RX_IRQ_EN  = 6'h07;
  localparam logic [5:0] ADDR_RX_STATUS  = 6'h08;
  localparam logic [5:0] ADDR_RX_DATA_A  = 6'h09;
  localparam logic [5:0] ADDR_RX_DATA_B  = 6'h0b;
  localparam logic [5:0] ADDR_SETTLE_CNT = 6'h38;

  // -------------------------------------------------------------------------
  // reset values
  // -------------------------------------------------------------------------
  localparam logic [7:0] RST_MODE_CTRL   = 8'h00;
  localparam logic [7:0] RST_CODE_RATE   = 8'h00;
  localparam logic [7:0] RST_IRQ_CFG     = 8'h01;
  localparam logic [7:0] RST_SER_CTRL    = 8'h03;
  localparam logic [7:0] RST_RX_IRQ_EN   = 8'h00;
  localparam logic [7:0] RST_SETTLE_CNT  = 8'h64;

  // -------------------------------------------------------------------------
  // writable bit masks (reserved bits read zero)
  // -------------------------------------------------------------------------
  localparam logic [7:0] MASK_MODE_CTRL  = 8'hfc;
  localparam logic [7:0] MASK_CODE_RATE  = 8'h07;
  localparam logic [7:0] MASK_IRQ_CFG    = 8'h03;
  localparam logic [7:0] MASK_SER_CTRL   = 8'h0f;

  // -------------------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------------------
  localparam int MC_RX_EN      = 7;
  localparam int MC_TX_EN      = 6;
  localparam int MC_HALF_SEL   = 5;
  localparam int MC_LOCK_BYP   = 4;
  localparam int MC_AMP_MAN    = 3;
  localparam int MC_AMP_ON     = 2;
  localparam int CR_WIDTH32    = 2;
  localparam int CR_DOUBLE     = 1;
  localparam int CR_SAMPLE12   = 0;
  localparam int SC_BYTE_MODE  = 3;
  localparam int IE_EOF_B      = 5;
  localparam int IE_FULL_B     = 4;
  localparam int IE_EOF_A      = 1;
  localparam int IE_FULL_A     = 0;
  localparam int CMD_WRITE     = 7;
  localparam int CMD_INCR      = 6;

  // -------------------------------------------------------------------------
  // timing: settle count unit is 2 us at a 50 MHz clock
  // -------------------------------------------------------------------------
  localparam int CLK_MHZ       = 50;
  localparam int SETTLE_UNIT_US = 2;
  localparam int SETTLE_UNIT_CYC = SETTLE_UNIT_US * CLK_MHZ;

  // interrupt pin styles
  localparam logic [1:0] IRQ_OPEN_SRC = 2'h3;
  localparam logic [1:0] IRQ_OPEN_DRN = 2'h2;
  localparam logic [1:0] IRQ_PP_HIGH  = 2'h1;
  localparam logic [1:0] IRQ_PP_LOW   = 2'h0;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_LOCK  = 4'b0010,
    ST_COUNT = 4'b0100,
    ST_READY = 4'b1000
  } rbm_settle_t;
endpackage

// >>> rtl/rbm_settle.sv
// rbm_settle: synthesizer settle sequencer after a mode enable
`timescale 1ns/1ps
module rbm_settle (
  // clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  // control
  input  wire logic       start_i,
  input  wire logic       bypass_i,
  input  wire logic [7:0] count_i,
  input  wire logic       lock_i,
  // status
  output logic            ready_o
);
  rbm_pkg::rbm_settle_t state_r;
  logic [7:0]           units_r;
  logic [7:0]           cyc_r;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i || !start_i) begin
      state_r <= rbm_pkg::ST_IDLE;
      units_r <= 8'h00;
      cyc_r   <= 8'h00;
    end else begin
      case (state_r)
        rbm_pkg::ST_IDLE: begin
          units_r <= 8'h00;
          cyc_r   <= 8'h00;
          state_r <= bypass_i ? rbm_pkg::ST_COUNT : rbm_pkg::ST_LOCK;
        end
        rbm_pkg::ST_LOCK: begin
          if (lock_i) begin
            state_r <= rbm_pkg::ST_COUNT;
          end
        end
        rbm_pkg::ST_COUNT: begin
          if (units_r >= count_i) begin
            state_r <= rbm_pkg::ST_READY;
          end else if (cyc_r == 8'(rbm_pkg::SETTLE_UNIT_CYC - 1)) begin
            cyc_r   <= 8'h00;
            units_r <= units_r + 8'h01;
          end else begin
            cyc_r <= cyc_r + 8'h01;
          end
        end
        rbm_pkg::ST_READY: state_r <= rbm_pkg::ST_READY;
        default: state_r <= rbm_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ready_o <= 1'b0;
    end else begin
      ready_o <= start_i && (state_r == rbm_pkg::ST_READY);
    end
  end

  // lock mode never becomes ready without lock
  property p_lock_wait;
    @(posedge ref_clk_i) disable iff (rst_i)
      (state_r == rbm_pkg::ST_LOCK && !lock_i) |=> state_r != rbm_pkg::ST_COUNT;
  endproperty
  a_lock_wait: assert property (p_lock_wait)
    else $error("settle left lock wait without lock");
endmodule

// >>> rtl/rbm_eof.sv
// rbm_eof: per-channel end-of-frame gap detector and data capture
`timescale 1ns/1ps
module rbm_eof (
  // clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  // config
  input  wire logic       rx_on_i,
  input  wire logic [2:0] gap_len_i,
  // bit stream
  input  wire logic       bit_tick_i,
  input  wire logic       bit_valid_i,
  input  wire logic       bit_data_i,
  // results
  output logic            eof_o,
  output logic            full_o,
  output logic [7:0]      data_o
);
  logic       seen_r;
  logic [2:0] gap_r;
  logic [2:0] cnt_r;
  logic [7:0] shift_r;
  logic       fire;

  assign fire = rx_on_i && bit_tick_i && !bit_valid_i && seen_r &&
                (gap_r >= gap_len_i);

  always_ff @(posedge ref_clk_i) begin
    if (rst_i || !rx_on_i) begin
      seen_r  <= 1'b0;
      gap_r   <= 3'h0;
      cnt_r   <= 3'h0;
      shift_r <= 8'h00;
    end else if (bit_tick_i) begin
      if (bit_valid_i) begin
        seen_r  <= 1'b1;
        gap_r   <= 3'h0;
        shift_r <= {bit_data_i, shift_r[7:1]};
        cnt_r   <= cnt_r + 3'h1;
      end else if (fire) begin
        seen_r <= 1'b0;
        gap_r  <= 3'h0;
        cnt_r  <= 3'h0;
      end else if (seen_r && gap_r != 3'h7) begin
        gap_r <= gap_r + 3'h1;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      eof_o  <= 1'b0;
      full_o <= 1'b0;
      data_o <= 8'h00;
    end else begin
      eof_o  <= fire;
      full_o <= fire || (rx_on_i && bit_tick_i && bit_valid_i &&
                         cnt_r == 3'h7);
      if (fire) begin
        data_o <= shift_r >> (4'h8 - {1'b0, cnt_r});
      end else if (rx_on_i && bit_tick_i && bit_valid_i && cnt_r == 3'h7) begin
        data_o <= {bit_data_i, shift_r[7:1]};
      end
    end
  end

  property p_eof_cause;
    @(posedge ref_clk_i) disable iff (rst_i)
      eof_o |-> $past(seen_r) && !$past(bit_valid_i) && $past(bit_tick_i);
  endproperty
  a_eof_cause: assert property (p_eof_cause)
    else $error("eof without a gap after valid data");

  property p_eof_zero;
    @(posedge ref_clk_i) disable iff (rst_i)
      (rx_on_i && gap_len_i == 3'h0 && seen_r && bit_tick_i && !bit_valid_i)
        |=> eof_o;
  endproperty
  a_eof_zero: assert property (p_eof_zero)
    else $error("zero gap did not fire at first invalid bit");

  property p_eof_full;
    @(posedge ref_clk_i) disable iff (rst_i)
      eof_o |-> full_o;
  endproperty
  a_eof_full: assert property (p_eof_full)
    else $error("eof did not transfer data");
endmodule

// >>> verif/rbm_host.sv
// rbm_host: serial port host model for register transfers
`timescale 1ns/1ps
module rbm_host (
  // clock and serial port
  input  wire logic ref_clk_i,
  input  wire logic spi_miso_i,
  output logic      spi_sck_o,
  output logic      spi_ss_n_o,
  output logic      spi_mosi_o
);
  initial {spi_sck_o, spi_ss_n_o, spi_mosi_o} = 3'h2;
  // command byte, then data
  // three clocks a half period keeps clear of the two-clock floor
  // nb bytes in all; the last two bytes, command byte included when nb is 2, come back in rd
  task automatic xfer(input logic [23:0] sh, input int nb,
                      output logic [15:0] rd);
    repeat (3) @(negedge ref_clk_i);
    spi_ss_n_o = 1'h0;
    for (int i = 8 * nb - 1; i >= 0; i--) begin
      spi_mosi_o = sh[i];
      repeat (3) @(negedge ref_clk_i);
      spi_sck_o = 1'h1;
      if (i < 16) rd[i] = spi_miso_i;
      repeat (3) @(negedge ref_clk_i);
      spi_sck_o = 1'h0;
    end
    repeat (3) @(negedge ref_clk_i);
    spi_ss_n_o = 1'h1;
    // released line toggles so a stale bit is never taken
    spi_mosi_o = ~spi_mosi_o;
  endtask
endmodule

// >>> verif/rbm_regs_tb.sv
// rbm_regs_tb: self-checking bench for the mode register bank
`timescale 1ns/1ps
module rbm_regs_tb;
  logic        ref_clk_i = 1'h0;
  logic        rst_i = 1'h1;
  logic        tick = 1'h0, va = 1'h0, da = 1'h0, lock = 1'h0;
  logic [7:0]  c, r, s, e;
  logic [15:0] v;
  logic [9:0]  x;
  wire         sck, ss_n, mosi, miso, irq, oe;
  wire  [10:0] m;
  integer      seed = 33663;
  int          n_mismatch = 0, samples_checked = 0;
  always #10 ref_clk_i = ~ref_clk_i;
  rbm_host i_host (.ref_clk_i(ref_clk_i), .spi_miso_i(miso),
    .spi_sck_o(sck), .spi_ss_n_o(ss_n), .spi_mosi_o(mosi));
  rbm_regs i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .spi_sck_i(sck),
    .spi_ss_n_i(ss_n), .spi_mosi_i(mosi), .spi_miso_o(miso),
    .bit_tick_i(tick), .bit_valid_a_i(va), .bit_data_a_i(da),
    .bit_valid_b_i(va), .bit_data_b_i(da), .synth_lock_i(lock),
    .rx_mode_o(m[10]), .tx_mode_o(m[9]), .code_upper_half_o(m[8]),
    .code_width32_o(m[7]), .double_rate_o(m[6]), .sample12_o(m[5]),
    .dual_code_o(m[4]), .amp_on_o(m[3]), .byte_mode_enable_o(m[2]),
    .bit_mode_enable_o(m[1]), .synth_ready_o(m[0]), .irq_o(irq),
    .irq_oe_o(oe));
  task automatic finish_test();
    $display("compares %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] ex, sn);
    samples_checked++;
    if (sn !== ex) begin
      n_mismatch++;
      $display("mismatch %s exp %h seen %h", nm, ex, sn);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    i_host.xfer({8'h00, 2'h2, a, d}, 2, v);
  endtask
  task automatic rc(input string nm, input logic [5:0] a, logic [7:0] ex);
    i_host.xfer({8'h00, 2'h0, a, 8'h00}, 2, v);
    chk(nm, ex, v[7:0]);
  endtask
  task automatic tk(input logic vv, dd);
    {va, da, tick} = {vv, dd, 1'h1};
    cyc(1);
    tick = 1'h0;
    cyc(4);
  endtask
  task automatic wait_rdy(input int n);
    for (int k = 0; k < n && m[0] !== 1'h1; k++) cyc(1);
    chk("ready", 16'h1, m[0]);
    if (m[0] !== 1'h1) finish_test();
  endtask
  // every pin style, idle or asserted
  task automatic pins(input logic act);
    for (int j = 0; j < 4; j++) begin
      wr(6'h05, 8'(j));
      cyc(3);
      r = {6'h00, ~j[1] | act, (~j[1] | act) & (act ~^ j[0])};
      chk("irq_pin", r, {oe, oe & irq});
    end
    wr(6'h05, 8'h01);
  endtask
  // channel b only counts in normal 32-chip rate
  task automatic eof_run(input logic [2:0] g, input logic [7:0] rt);
    wr(6'h06, {5'h01, g});
    wr(6'h04, rt);
    wr(6'h07, rt[2] ? 8'h20 : 8'h02);
    wr(6'h03, 8'h80);
    tk(1'h1, 1'h1);
    tk(1'h1, 1'h0);
    tk(1'h1, 1'h1);
    for (int t = 0; t < g; t++) tk(1'h0, 1'h0);
    chk("irq_gap", 16'h0, irq);
    tk(1'h0, 1'h0);
    chk("irq_eof", 16'h1, irq);
    pins(1'h1);
    rc("status", 6'h08, rt[2] ? 8'h33 : 8'h03);
    cyc(3);
    chk("irq_clr", 16'h0, irq);
    rc("data_a", 6'h09, 8'h05);
    rc("data_b", 6'h0b, rt[2] ? 8'h05 : 8'h00);
    wr(6'h03, 8'h00);
  endtask
  initial begin
    cyc(5);
    rst_i = 1'h0;
    for (int i = 0; i < 5; i++)
      rc("reset", 6'h03 + 6'(i), 8'(40'h0003010000 >> (8 * i)));
    rc("reset_cnt", 6'h38, 8'h64);
    rc("unmapped", 6'h01, 8'h00);
    for (int i = 0; i < 8; i++) begin
      c = ($random(seed) & 8'hf4) | 8'h08;
      s = $random(seed) & 8'h0f;
      e = $random(seed);
      r = (i % 4 == 0) ? 8'h00 : 8'(3 + i % 4);
      wr(6'h03, c);
      wr(6'h04, r);
      wr(6'h06, s);
      wr(6'h07, e);
      rc("ctrl", 6'h03, c);
      rc("rate", 6'h04, r);
      rc("ser", 6'h06, s);
      rc("irq_en", 6'h07, e);
      // half select has no meaning once double rate uses both halves
      x = {c[7:6], c[5] & r[2] & ~r[1], r[2:0], r[2] & ~r[1], c[2],
           s[3], ~s[3]};
      chk("mode_hi", x[9:5], m[10:6]);
      chk("mode_lo", x[4:0], m[5:1]);
      i_host.xfer({2'h1, 6'h03, 16'h0000}, 3, v);
      chk("burst", {c, r}, v);
    end
    wr(6'h04, 8'h00);
    wr(6'h03, 8'h00);
    pins(1'h0);
    eof_run(3'h0, 8'h00);
    eof_run(3'h7, 8'h04);
    wr(6'h38, 8'h02);
    wr(6'h03, 8'h50);
    cyc(150);
    chk("early", 16'h0, m[0]);
    wait_rdy(100);
    // amplifier follows ready one clock later
    cyc(2);
    chk("amp_auto", 16'h1, m[3]);
    wr(6'h03, 8'h00);
    // count 25 when waiting on lock
    wr(6'h38, 8'h19);
    wr(6'h03, 8'h40);
    cyc(3000);
    chk("lock_wait", 16'h0, m[0]);
    lock = 1'h1;
    wait_rdy(2600);
    finish_test();
  end
endmodule
